/* shared/tcct_pkg.sv */
// shared constants of the type-c cc timing core
package tcct_pkg;
    localparam int CLK_HZ         = 50_000_000;
    localparam int CLK_PER_MS     = CLK_HZ / 1000;
    // timebase tick every millisecond
    localparam int TICK_CYCLES    = CLK_PER_MS;
    // debounce and dwell targets in ms, chosen inside the legal windows
    localparam int DEB_MS         = 15;   // 10..20 ms windows
    localparam int RECOVERY_MS    = 50;   // 25..100 ms
    localparam int TRY_MS         = 100;  // 75..150 ms
    localparam int TRY_TIMEOUT_MS = 800;  // 550..1100 ms
    localparam int ENABLE_MS      = 90;   // below 100 ms
    // vbus valid rise debounce in us, 250..500 us
    localparam int VBUS_RISE_US   = 375;
    // scaled through clocks per ms so the product stays inside an int
    localparam int VBUS_RISE_CYC  = (VBUS_RISE_US * CLK_PER_MS) / 1000;
    localparam int ATTACH_DEB_RST = 150;  // default attach debounce, ms
    localparam int TOGGLE_PER_RST = 100;  // default toggle period, ms
    localparam logic [1:0] RATIO_RST = 2'h0;
    // register map, word offsets
    localparam logic [3:0] A_CTRL   = 4'h0;
    localparam logic [3:0] A_ATTDEB = 4'h1;
    localparam logic [3:0] A_TOGPER = 4'h2;
    localparam logic [3:0] A_STATUS = 4'h3;
    localparam logic [3:0] A_IRQ    = 4'h4;
    localparam logic [3:0] A_MASK   = 4'h5;
    localparam int NEV = 6;
    typedef enum logic [5:0] {
        ST_UNATT_SNK = 6'b00_0001,
        ST_UNATT_SRC = 6'b00_0010,
        ST_ATTACHED  = 6'b00_0100,
        ST_TRY       = 6'b00_1000,
        ST_TRY_WAIT  = 6'b01_0000,
        ST_RECOVERY  = 6'b10_0000
    } tcct_state_type;
endpackage

/* hdl/tcct_core.sv */
// timing core of a type-c configuration channel port controller
`timescale 1ns/1ns
module tcct_core #(
    parameter int TICK_CYCLES = tcct_pkg::TICK_CYCLES,  // clocks per ms tick
    parameter int RISE_CYCLES = tcct_pkg::VBUS_RISE_CYC // vbus rise debounce
) (
    input  wire logic       clock,          // 50 mhz clock
    input  wire logic       rst,            // synchronous reset, high
    input  wire logic       enable_n,       // device enable, low active
    input  wire logic       cc_attach_raw,  // analog partner present
    input  wire logic [1:0] rp_level_raw,   // sensed source pull-up level
    input  wire logic       weak_batt_raw,  // supply below weak threshold
    input  wire logic       vbus_sense_input, // vbus above threshold
    input  wire logic       try_enable,     // use try.src/snk on attach
    input  wire logic       role_change,    // pulse: port role changed
    input  wire logic [3:0] reg_addr,       // register word address
    input  wire logic [15:0] reg_wdata,     // write data
    input  wire logic       reg_wr,         // write strobe
    input  wire logic       reg_rd,         // read strobe
    output logic [15:0]     reg_rdata,      // read data, cycle after rd
    output logic            host_ready,     // i2c configuration available
    output logic            source_role,    // presenting rp when high
    output logic            attached,       // partner attached
    output logic [1:0]      rp_level,       // debounced pull-up level
    output logic            vbus_valid_flag, // debounced vbus valid
    output logic            weak_battery_sink_mode, // auto sink active
    output logic            irq             // level interrupt
);
    localparam int NEV_W = tcct_pkg::NEV;
    logic [15:0] tick_cnt;
    logic        tick;
    tcct_pkg::tcct_state_type state;
    logic [10:0] st_ms;           // ms spent in current state
    logic [15:0] deb_ms;          // cc debounce counter
    logic [15:0] togper;
    logic [15:0] attdeb;
    logic [1:0]  toggle_ratio_select;
    logic        recovery_request_bit;
    logic        weak_en;
    logic        en_seen;
    logic [6:0]  en_ms;
    logic [4:0]  rp_ms;
    logic [4:0]  wb_ms;
    logic [4:0]  vf_ms;
    logic [15:0] vr_cyc;
    logic [15:0] snk_dwell;
    logic [NEV_W-1:0] irq_stat;
    logic [NEV_W-1:0] irq_mask;
    logic [NEV_W-1:0] ev;
    logic        was_attached;
    logic        was_vbus;

    // single timebase shared by every ms timer
    always_ff @(posedge clock) begin
        if (rst || tick) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end
    assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));

    // enable gating of host access
    always_ff @(posedge clock) begin
        if (rst || enable_n) begin
            en_ms      <= 7'h00;
            host_ready <= 1'b0;
        end else if (tick && !host_ready) begin
            en_ms <= en_ms + 7'h01;
            if (en_ms == 7'(tcct_pkg::ENABLE_MS - 1)) begin
                host_ready <= 1'b1;
            end
        end
    end

    // sink dwell = period * percent / 100, per ratio select
    always_comb begin
        case (toggle_ratio_select)
            2'h0:    snk_dwell = 16'((32'(togper) * 70) / 100);
            2'h1:    snk_dwell = 16'((32'(togper) * 60) / 100);
            2'h2:    snk_dwell = 16'((32'(togper) * 50) / 100);
            default: snk_dwell = 16'((32'(togper) * 40) / 100);
        endcase
    end

    // main port state machine; state changes take effect in one cycle
    always_ff @(posedge clock) begin
        if (rst || enable_n) begin
            state  <= tcct_pkg::ST_UNATT_SNK;
            st_ms  <= 11'h000;
            deb_ms <= 16'h0000;
        end else if (recovery_request_bit || role_change) begin
            state  <= tcct_pkg::ST_RECOVERY;
            st_ms  <= 11'h000;
            deb_ms <= 16'h0000;
        end else begin
            if (tick) begin
                st_ms <= st_ms + 11'h001;
            end
            case (state)
                tcct_pkg::ST_UNATT_SNK, tcct_pkg::ST_UNATT_SRC: begin
                    // debounce restarts whenever the partner vanishes
                    if (!cc_attach_raw) begin
                        deb_ms <= 16'h0000;
                    end else if (tick) begin
                        deb_ms <= deb_ms + 16'h0001;
                    end
                    if (cc_attach_raw && deb_ms >= attdeb) begin
                        state  <= try_enable ? tcct_pkg::ST_TRY
                                             : tcct_pkg::ST_ATTACHED;
                        st_ms  <= 11'h000;
                        deb_ms <= 16'h0000;
                    end else if (state == tcct_pkg::ST_UNATT_SNK &&
                                 16'(st_ms) >= snk_dwell) begin
                        state <= tcct_pkg::ST_UNATT_SRC;
                        st_ms <= 11'h000;
                    end else if (state == tcct_pkg::ST_UNATT_SRC &&
                                 16'(st_ms) >= togper - snk_dwell) begin
                        state <= tcct_pkg::ST_UNATT_SNK;
                        st_ms <= 11'h000;
                    end
                end
                tcct_pkg::ST_ATTACHED: begin
                    // same window serves sink detach and source open
                    if (cc_attach_raw) begin
                        deb_ms <= 16'h0000;
                    end else if (tick) begin
                        deb_ms <= deb_ms + 16'h0001;
                    end
                    if (!cc_attach_raw &&
                        deb_ms >= 16'(tcct_pkg::DEB_MS)) begin
                        state  <= tcct_pkg::ST_UNATT_SNK;
                        st_ms  <= 11'h000;
                        deb_ms <= 16'h0000;
                    end
                end
                tcct_pkg::ST_TRY: begin
                    if (st_ms >= 11'(tcct_pkg::TRY_MS)) begin
                        state  <= tcct_pkg::ST_TRY_WAIT;
                        st_ms  <= 11'h000;
                        deb_ms <= 16'h0000;
                    end
                end
                tcct_pkg::ST_TRY_WAIT: begin
                    if (!cc_attach_raw) begin
                        deb_ms <= 16'h0000;
                    end else if (tick) begin
                        deb_ms <= deb_ms + 16'h0001;
                    end
                    if (cc_attach_raw &&
                        deb_ms >= 16'(tcct_pkg::DEB_MS)) begin
                        state <= tcct_pkg::ST_ATTACHED;
                        st_ms <= 11'h000;
                        deb_ms <= 16'h0000;
                    end else if (st_ms >= 11'(tcct_pkg::TRY_TIMEOUT_MS))
                    begin
                        state <= tcct_pkg::ST_UNATT_SNK;
                        st_ms <= 11'h000;
                    end
                end
                tcct_pkg::ST_RECOVERY: begin
                    if (st_ms >= 11'(tcct_pkg::RECOVERY_MS)) begin
                        state <= tcct_pkg::ST_UNATT_SNK;
                        st_ms <= 11'h000;
                    end
                end
                default: begin
                    state <= tcct_pkg::ST_UNATT_SNK;
                    st_ms <= 11'h000;
                end
            endcase
        end
    end
    assign source_role = (state == tcct_pkg::ST_UNATT_SRC);
    assign attached    = (state == tcct_pkg::ST_ATTACHED);

    // pull-up level change must hold before it is reported
    always_ff @(posedge clock) begin
        if (rst) begin
            rp_level <= 2'h0;
            rp_ms    <= 5'h00;
        end else if (rp_level_raw == rp_level) begin
            rp_ms <= 5'h00;
        end else if (tick) begin
            rp_ms <= rp_ms + 5'h01;
            if (rp_ms == 5'(tcct_pkg::DEB_MS - 1)) begin
                rp_level <= rp_level_raw;
                rp_ms    <= 5'h00;
            end
        end
    end

    // weak battery auto sink, symmetric debounce
    always_ff @(posedge clock) begin
        if (rst || !weak_en) begin
            weak_battery_sink_mode <= 1'b0;
            wb_ms                  <= 5'h00;
        end else if (weak_batt_raw == weak_battery_sink_mode) begin
            wb_ms <= 5'h00;
        end else if (tick) begin
            wb_ms <= wb_ms + 5'h01;
            if (wb_ms == 5'(tcct_pkg::DEB_MS - 1)) begin
                weak_battery_sink_mode <= weak_batt_raw;
                wb_ms                  <= 5'h00;
            end
        end
    end

    // vbus valid: fast rise in cycles, slow fall in ms
    always_ff @(posedge clock) begin
        if (rst || vbus_sense_input == vbus_valid_flag) begin
            vr_cyc <= 16'h0000;
            vf_ms  <= 5'h00;
            if (rst) begin
                vbus_valid_flag <= 1'b0;
            end
        end else if (vbus_sense_input) begin
            vr_cyc <= vr_cyc + 16'h0001;
            if (vr_cyc == 16'(RISE_CYCLES - 1)) begin
                vbus_valid_flag <= 1'b1;
            end
        end else if (tick) begin
            vf_ms <= vf_ms + 5'h01;
            if (vf_ms == 5'(tcct_pkg::DEB_MS - 1)) begin
                vbus_valid_flag <= 1'b0;
            end
        end
    end

    // event edges, plus the weak mode and recovery levels, for the interrupt status
    always_ff @(posedge clock) begin
        if (rst) begin
            was_attached <= 1'b0;
            was_vbus     <= 1'b0;
        end else begin
            was_attached <= attached;
            was_vbus     <= vbus_valid_flag;
        end
    end
    assign ev = {state == tcct_pkg::ST_RECOVERY,
                 weak_battery_sink_mode,
                 vbus_valid_flag != was_vbus,
                 rp_ms == 5'(tcct_pkg::DEB_MS - 1) && tick,
                 !attached && was_attached,
                 attached && !was_attached};

    // configuration registers
    always_ff @(posedge clock) begin
        if (rst) begin
            toggle_ratio_select  <= tcct_pkg::RATIO_RST;
            recovery_request_bit <= 1'b0;
            weak_en              <= 1'b0;
            attdeb               <= 16'(tcct_pkg::ATTACH_DEB_RST);
            togper               <= 16'(tcct_pkg::TOGGLE_PER_RST);
            irq_mask             <= '0;
        end else begin
            // request bit is self-clearing after one cycle
            recovery_request_bit <= 1'b0;
            if (reg_wr && host_ready) begin
                case (reg_addr)
                    tcct_pkg::A_CTRL: begin
                        toggle_ratio_select  <= reg_wdata[1:0];
                        weak_en              <= reg_wdata[2];
                        recovery_request_bit <= reg_wdata[3];
                    end
                    tcct_pkg::A_ATTDEB: attdeb   <= reg_wdata;
                    tcct_pkg::A_TOGPER: togper   <= reg_wdata;
                    tcct_pkg::A_MASK:   irq_mask <= reg_wdata[NEV_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // sticky status, write one to clear; a new event wins
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_stat <= '0;
        end else if (reg_wr && host_ready && reg_addr == tcct_pkg::A_IRQ)
        begin
            irq_stat <= (irq_stat & ~reg_wdata[NEV_W-1:0]) | ev;
        end else begin
            irq_stat <= irq_stat | ev;
        end
    end
    assign irq = |(irq_stat & irq_mask);

    always_ff @(posedge clock) begin
        if (rst || !reg_rd || !host_ready) begin
            reg_rdata <= 16'h0000;
        end else begin
            case (reg_addr)
                tcct_pkg::A_CTRL:
                    reg_rdata <= {13'h0000, weak_en, toggle_ratio_select};
                tcct_pkg::A_ATTDEB: reg_rdata <= attdeb;
                tcct_pkg::A_TOGPER: reg_rdata <= togper;
                tcct_pkg::A_STATUS:
                    reg_rdata <= {4'h0, rp_level, vbus_valid_flag,
                                  weak_battery_sink_mode, 2'h0, state};
                tcct_pkg::A_IRQ:
                    reg_rdata <= {{(16-NEV_W){1'b0}}, irq_stat};
                tcct_pkg::A_MASK:
                    reg_rdata <= {{(16-NEV_W){1'b0}}, irq_mask};
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end
endmodule

/* verification/tcct_core_chk.sv */
// concurrent checks on the ports of the type-c cc timing core
`timescale 1ns/1ns
module tcct_core_chk #(
    parameter int MS = tcct_pkg::CLK_PER_MS                 // clocks per ms
) (
    input wire logic        clock,                  // 50 mhz clock
    input wire logic        rst,                    // synchronous reset
    input wire logic        enable_n,               // device enable, low
    input wire logic        cc_attach_raw,          // raw partner detect
    input wire logic [1:0]  rp_level_raw,           // raw pull-up level
    input wire logic        weak_batt_raw,          // raw weak supply
    input wire logic        vbus_sense_input,       // raw vbus
    input wire logic        role_change,            // role change pulse
    input wire logic        reg_rd,                 // read strobe
    input wire logic [15:0] reg_rdata,              // read data
    input wire logic        host_ready,             // host access open
    input wire logic        attached,               // partner attached
    input wire logic [1:0]  rp_level,               // debounced level
    input wire logic        vbus_valid_flag,        // debounced vbus
    input wire logic        weak_battery_sink_mode  // auto sink active
);
    logic [22:0] en_cnt, vb_hi, vb_lo, wk_st, cc_lo, rp_st, rc_cnt;
    logic [1:0]  rp_prev;
    logic        wk_prev;

    // saturating, so long idle stretches never wrap into a short count
    function automatic logic [22:0] count_up(input logic [22:0] c,
                                             input logic go);
        return go ? c + {22'h0, ~&c} : 23'h0;
    endfunction

    always_ff @(posedge clock) begin
        if (rst) begin
            en_cnt <= 23'h0;
            vb_hi  <= 23'h0;
            vb_lo  <= 23'h0;
            wk_st  <= 23'h0;
            cc_lo  <= 23'h0;
            rp_st  <= 23'h0;
            rc_cnt <= 23'h7f_ffff;
        end else begin
            en_cnt <= count_up(en_cnt, !enable_n);
            vb_hi  <= count_up(vb_hi, vbus_sense_input);
            vb_lo  <= count_up(vb_lo, !vbus_sense_input);
            wk_st  <= count_up(wk_st, weak_batt_raw == wk_prev);
            cc_lo  <= count_up(cc_lo, !cc_attach_raw);
            rp_st  <= count_up(rp_st, rp_level_raw == rp_prev);
            rc_cnt <= role_change ? 23'h0 : count_up(rc_cnt, 1'b1);
        end
        rp_prev <= rp_level_raw;
        wk_prev <= weak_batt_raw;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    a_read_data_gated: assert property (
        !($past(reg_rd) && $past(host_ready)) |-> reg_rdata == 16'h0000)
        else $error("read data outside an accepted read");
    a_host_ready_time: assert property ($rose(host_ready) |->
        en_cnt >= 23'(88 * MS) && en_cnt <= 23'(100 * MS))
        else $error("host access opened at the wrong time");
    a_vbus_rise_deb: assert property ($rose(vbus_valid_flag) |->
        vb_hi >= 23'(MS / 4) && vb_hi <= 23'(MS / 2))
        else $error("vbus valid rose outside its debounce");
    a_vbus_fall_deb: assert property ($fell(vbus_valid_flag) |->
        vb_lo >= 23'(10 * MS) && vb_lo <= 23'(20 * MS))
        else $error("vbus valid fell outside its debounce");
    a_weak_mode_deb: assert property (
        $changed(weak_battery_sink_mode) |-> wk_st >= 23'(10 * MS))
        else $error("weak battery mode changed too early");
    a_detach_deb: assert property ($fell(attached) && !cc_attach_raw
        |-> cc_lo >= 23'(10 * MS) && cc_lo <= 23'(20 * MS))
        else $error("detach outside its debounce");
    a_rp_change_deb: assert property (
        $changed(rp_level) |-> rp_st >= 23'(10 * MS))
        else $error("pull-up level taken too early");
    a_recovery_hold: assert property (
        $rose(attached) |-> rc_cnt >= 23'(25 * MS))
        else $error("attach during error recovery");
endmodule

bind tcct_core tcct_core_chk #(.MS(TICK_CYCLES)) tcct_core_chk_i (
    .clock, .rst, .enable_n, .cc_attach_raw, .rp_level_raw, .weak_batt_raw,
    .vbus_sense_input, .role_change, .reg_rd, .reg_rdata, .host_ready,
    .attached, .rp_level, .vbus_valid_flag, .weak_battery_sink_mode
);

/* verification/tcct_partner.sv */
// behavioural port partner across the connector
`timescale 1ns/1ns
module tcct_partner (
    input  wire logic       clock,            // bench clock
    input  wire logic       want_attach,      // partner plugged in
    input  wire logic [1:0] want_rp,          // level to advertise
    input  wire logic       want_vbus,        // partner sources vbus
    output logic            cc_attach_raw,    // partner seen on cc
    output logic [1:0]      rp_level_raw,     // advertised level
    output logic            vbus_sense_input  // vbus above threshold
);
    // an unplugged partner shows neither a pull-up nor vbus
    always_ff @(posedge clock) begin
        cc_attach_raw    <= want_attach;
        rp_level_raw     <= want_attach ? want_rp : 2'h0;
        vbus_sense_input <= want_attach & want_vbus;
    end
endmodule

/* verification/tcct_core_bench.sv */
// self-checking bench of the type-c cc timing core
`timescale 1ns/1ns
`define CHECK(what, exp, got) begin #1; n_compared++; \
    if ((got) !== (exp)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", what, exp, got); end end
module tcct_core_bench;
    // clocks per ms tick, scaled down so the long timers fit a short run
    localparam int MS = 50;
    logic        clock, rst, enable_n, weak_batt_raw, try_enable;
    logic        role_change, reg_wr, reg_rd, want_attach, want_vbus;
    logic [1:0]  want_rp, rp_level_raw, rp_level;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd;
    logic        cc_attach_raw, vbus_sense_input, host_ready, source_role;
    logic        attached, vbus_valid_flag, weak_battery_sink_mode, irq;
    int          fail_count = 0;
    int          n_compared = 0;
    int          n, m;
    int          sink_pct[4] = '{70, 60, 50, 40};
    logic [3:0]  ra[4] = '{tcct_pkg::A_ATTDEB, tcct_pkg::A_TOGPER,
                           tcct_pkg::A_MASK, 4'hf};
    logic [15:0] rv[4] = '{16'h0096, 16'h0064, 16'h0000, 16'h0000};

    tcct_partner tcct_partner_i (.clock, .want_attach, .want_rp, .want_vbus,
        .cc_attach_raw, .rp_level_raw, .vbus_sense_input);
    tcct_core #(.TICK_CYCLES(MS),
        .RISE_CYCLES(tcct_pkg::VBUS_RISE_US * MS / 1000))
        tcct_core_i (.clock, .rst, .enable_n, .cc_attach_raw,
        .rp_level_raw, .weak_batt_raw, .vbus_sense_input, .try_enable,
        .role_change, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .host_ready, .source_role, .attached, .rp_level, .vbus_valid_flag,
        .weak_battery_sink_mode, .irq);

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic complete_run();
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clock);
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    function automatic logic pick(input int sel);
        return sel == 0 ? attached : (sel == 1 ? source_role : host_ready);
    endfunction

    // a wait that runs out is a failure and ends the run
    task automatic wait_for(input int sel, input logic lvl, input int lim,
                            output int c);
        c = 0;
        while (pick(sel) !== lvl && c < lim) begin
            @(posedge clock);
            #1 c++;
        end
        if (c >= lim) begin
            fail_count++;
            complete_run();
        end
    endtask

    // dwell within one timebase tick of pct of a 10 ms period
    function automatic logic in_ms(input int c, input int pct);
        return c >= pct * MS / 10 - MS && c <= pct * MS / 10 + MS;
    endfunction

    initial begin
        rst = 1'b1;
        enable_n = 1'b0;
        weak_batt_raw = 1'b0;
        try_enable = 1'b0;
        role_change = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        want_attach = 1'b0;
        want_vbus = 1'b0;
        want_rp = 2'h0;
        tick(10);
        rst <= 1'b0;
        reg_read(tcct_pkg::A_TOGPER, rd);
        `CHECK("early read", 16'h0000, rd)
        wait_for(2, 1'b1, 100 * MS, n);
        `CHECK("host ready", 1'b1, host_ready)
        foreach (ra[i]) begin
            reg_read(ra[i], rd);
            `CHECK("reset value", rv[i], rd)
        end
        reg_write(tcct_pkg::A_ATTDEB, 16'h0003);
        reg_write(tcct_pkg::A_TOGPER, 16'h000a);
        for (int i = 3; i >= 0; i--) begin
            reg_write(tcct_pkg::A_CTRL, 16'(i));
            wait_for(1, 1'b1, 12 * MS, n);
            wait_for(1, 1'b0, 12 * MS, n);
            wait_for(1, 1'b1, 12 * MS, n);
            `CHECK("sink dwell", 1'b1, in_ms(n, sink_pct[i]))
            wait_for(1, 1'b0, 12 * MS, m);
            `CHECK("source dwell", 1'b1, in_ms(m, 100 - sink_pct[i]))
            `CHECK("toggle period", 1'b1, in_ms(n + m, 100))
        end
        // attach at the start of a sink dwell so the port becomes a sink
        tick(1);
        want_attach <= 1'b1;
        wait_for(0, 1'b1, 4 * MS, n);
        `CHECK("attach debounce", 1'b1, n >= 19 * MS / 10)
        reg_read(tcct_pkg::A_STATUS, rd);
        `CHECK("status attached", 1'b1, rd[2])
        reg_read(tcct_pkg::A_IRQ, rd);
        `CHECK("attach event", 1'b1, rd[0])
        `CHECK("irq masked", 1'b0, irq)
        reg_write(tcct_pkg::A_MASK, 16'h0001);
        tick(1);
        `CHECK("irq raised", 1'b1, irq)
        reg_write(tcct_pkg::A_IRQ, 16'h0001);
        tick(1);
        `CHECK("irq cleared", 1'b0, irq)
        reg_write(tcct_pkg::A_CTRL, 16'h0004);
        want_vbus <= 1'b1;
        want_rp <= 2'h1;
        weak_batt_raw <= 1'b1;
        tick(MS / 5);
        `CHECK("vbus early", 1'b0, vbus_valid_flag)
        tick(MS * 7 / 20);
        `CHECK("vbus valid", 1'b1, vbus_valid_flag)
        tick(9 * MS);
        `CHECK("weak early", 1'b0, weak_battery_sink_mode)
        `CHECK("rp early", 2'h0, rp_level)
        tick(11 * MS);
        `CHECK("weak mode", 1'b1, weak_battery_sink_mode)
        `CHECK("rp level", 2'h1, rp_level)
        tick(1);
        want_attach <= 1'b0;
        weak_batt_raw <= 1'b0;
        tick(9 * MS);
        `CHECK("detach early", 1'b1, attached)
        `CHECK("vbus hold", 1'b1, vbus_valid_flag)
        `CHECK("weak hold", 1'b1, weak_battery_sink_mode)
        tick(23 * MS / 2);
        `CHECK("detached", 1'b0, attached)
        `CHECK("vbus gone", 1'b0, vbus_valid_flag)
        `CHECK("weak gone", 1'b0, weak_battery_sink_mode)
        tick(1);
        want_attach <= 1'b1;
        wait_for(0, 1'b1, 20 * MS, n);
        tick(1);
        role_change <= 1'b1;
        tick(1);
        role_change <= 1'b0;
        tick(24 * MS);
        `CHECK("in recovery", 1'b0, attached)
        wait_for(0, 1'b1, 80 * MS, n);
        `CHECK("re-attached", 1'b1, attached)
        // partner lost during try: no toggling until the try wait times out
        tick(1);
        try_enable <= 1'b1;
        want_attach <= 1'b0;
        wait_for(0, 1'b0, 20 * MS, n);
        tick(1);
        want_attach <= 1'b1;
        tick(10 * MS);
        reg_read(tcct_pkg::A_STATUS, rd);
        `CHECK("in try", 1'b1, rd[3])
        tick(1);
        want_attach <= 1'b0;
        wait_for(1, 1'b1, 1300 * MS, n);
        `CHECK("try timeout", 1'b1, n >= 550 * MS)
        tick(1);
        want_attach <= 1'b1;
        wait_for(0, 1'b1, 200 * MS, n);
        `CHECK("try path", 1'b1, n >= 87 * MS && n <= 174 * MS)
        reg_write(tcct_pkg::A_CTRL, 16'h0008);
        reg_read(tcct_pkg::A_STATUS, rd);
        `CHECK("requested recovery", 1'b1, rd[5])
        `CHECK("left attached", 1'b0, attached)
        complete_run();
    end
endmodule
